// ===== shared/rivm_pkg.sv
/*
  shared constants for the reset and interrupt vector mapper:
  vector numbers, table offsets, address widths and reset defaults.
  assumes a word-addressed program memory of 4K words.
*/
`default_nettype none

package rivm_pkg;

  // ==========================================================================
  // sizes
  localparam int unsigned RIVM_ADDR_W   = 12;   // word address width
  localparam int unsigned RIVM_NUM_IRQ  = 25;   // peripheral sources
  localparam int unsigned RIVM_NUM_W    = 5;    // width of a source index

  // ==========================================================================
  // fixed addresses
  localparam logic [11:0] RIVM_RESET_VEC   = 12'h000;
  localparam logic [11:0] RIVM_TABLE_BASE  = 12'h001;  // offset of first irq
  localparam logic [11:0] RIVM_LAST_OFFSET = 12'h019;
  localparam logic [11:0] RIVM_BOOT_START_DEF = 12'hc00; // boot section start

  // ==========================================================================
  // fuse encodings
  localparam logic RIVM_FUSE_PROGRAMMED   = 1'b0;
  localparam logic RIVM_FUSE_UNPROGRAMMED = 1'b1;

  // ==========================================================================
  // source indices (bit positions of the request vector)
  localparam int unsigned RIVM_SRC_EXT0     = 0;
  localparam int unsigned RIVM_SRC_EXT1     = 1;
  localparam int unsigned RIVM_SRC_PC0      = 2;
  localparam int unsigned RIVM_SRC_PC1      = 3;
  localparam int unsigned RIVM_SRC_PC2      = 4;
  localparam int unsigned RIVM_SRC_WDOG     = 5;
  localparam int unsigned RIVM_SRC_T2_A     = 6;
  localparam int unsigned RIVM_SRC_T2_B     = 7;
  localparam int unsigned RIVM_SRC_T2_OVF   = 8;
  localparam int unsigned RIVM_SRC_T1_CAP   = 9;
  localparam int unsigned RIVM_SRC_T1_A     = 10;
  localparam int unsigned RIVM_SRC_T1_B     = 11;
  localparam int unsigned RIVM_SRC_T1_OVF   = 12;
  localparam int unsigned RIVM_SRC_T0_A     = 13;
  localparam int unsigned RIVM_SRC_T0_B     = 14;
  localparam int unsigned RIVM_SRC_T0_OVF   = 15;
  localparam int unsigned RIVM_SRC_SPI      = 16;
  localparam int unsigned RIVM_SRC_RX       = 17;
  localparam int unsigned RIVM_SRC_TXE      = 18;
  localparam int unsigned RIVM_SRC_TXC      = 19;
  localparam int unsigned RIVM_SRC_CONV     = 20;
  localparam int unsigned RIVM_SRC_NV       = 21;
  localparam int unsigned RIVM_SRC_ACMP     = 22;
  localparam int unsigned RIVM_SRC_TWO_WIRE = 23;
  localparam int unsigned RIVM_SRC_PSTORE   = 24;

  // ==========================================================================
  // fetch sequencer states
  typedef enum logic [1:0] {
    RIVM_ST_RESET,
    RIVM_ST_IDLE,
    RIVM_ST_WAIT
  } rivm_state_type;

endpackage

`default_nettype wire

// ===== logic/rivm_prio_enc.sv
/*
  fixed priority encoder over the pending requests: lowest index wins.
  assumes requests are already gated by their enables.
*/
`timescale 1ns/1ps
`default_nettype none

module rivm_prio_enc
  import rivm_pkg::*;
#(
  parameter int unsigned N = RIVM_NUM_IRQ,
  parameter int unsigned W = RIVM_NUM_W
) (
  // requests
  input  wire logic [N-1:0] req_i,
  // result
  output logic               any_o,
  output logic [W-1:0]       idx_o
);

  // ==========================================================================
  // scan from the top so the lowest set bit is written last
  always_comb begin
    any_o = 1'b0;
    idx_o = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req_i[i]) begin
        any_o = 1'b1;
        idx_o = W'(i);
      end
    end
  end

endmodule

`default_nettype wire

// ===== logic/rivm_addr_map.sv
/*
  maps a source index to its program word address, with relocation of
  the table into the boot section when the select bit is set.
  assumes the boot start lies far enough below the top that no sum wraps.
*/
`timescale 1ns/1ps
`default_nettype none

module rivm_addr_map
  import rivm_pkg::*;
#(
  parameter int unsigned AW = RIVM_ADDR_W,
  parameter int unsigned W  = RIVM_NUM_W
) (
  // inputs
  input  wire logic [W-1:0]  idx_i,
  input  wire logic          table_sel_i,
  input  wire logic [AW-1:0] boot_start_i,
  // result
  output logic [AW-1:0]      addr_o
);

  logic [AW-1:0] offset;

  // ==========================================================================
  // one word per vector, index 0 sits at table base
  always_comb begin
    offset = AW'(RIVM_TABLE_BASE) + AW'(idx_i);
    addr_o = table_sel_i ? AW'(boot_start_i + offset) : offset;
  end

endmodule

`default_nettype wire

// ===== logic/rivm_top.sv
/*
  reset and interrupt vector mapper. after reset it presents the reset
  vector to the core; afterwards it picks the highest priority enabled
  request and presents its vector address with a valid strobe that is
  held until the core acknowledges the fetch.
  assumes all inputs are synchronous to clk_i, the core acknowledges
  with ack_i for one cycle, and request lines stay high until served.
  no pending latch is kept: a request that drops before it is picked
  is lost, which suits level flags that peripherals clear on service.
  reset sources of every kind arrive merged on arst_n_i.
  the boot section start is a parameter; section sizing lives elsewhere.
*/
`timescale 1ns/1ps
`default_nettype none

// Function
// - after any reset, present reset vector, word 0x000 when fuse unprogrammed.
// - external request 0 maps to 0x001, request 1 to 0x002.
// - pin change 0..2 map to 0x003..0x005, watchdog to 0x006.
// - timer 2 match a, match b, overflow map to 0x007..0x009.
// - timer 1 capture, match a, match b, overflow map to 0x00a..0x00d.
// - timer 0 match a, match b, overflow map to 0x00e..0x010.
// - serial peripheral transfer complete maps to 0x011.
// - receive, tx buffer empty, tx complete map to 0x012..0x014.
// - conversion, nv data ready, comparator map to 0x015..0x017.
// - two wire maps to 0x018, program store ready 0x019, last entry.
// - programmed fuse sends every reset to the boot loader address.
// - select bit set adds boot section start to each vector offset.
// - fuse 1 unprogrammed, 0 programmed; table at 0x001 or boot plus 0x001.
module rivm_top
  import rivm_pkg::*;
#(
  parameter int unsigned        AW         = RIVM_ADDR_W,
  parameter int unsigned        N          = RIVM_NUM_IRQ,
  parameter logic [AW-1:0]      BOOT_START = RIVM_BOOT_START_DEF
) (
  // clock and reset
  input  wire logic          clk_i,
  input  wire logic          arst_n_i,
  // relocation controls
  input  wire logic          boot_reset_fuse_i,
  input  wire logic          vector_table_select_i,
  // external and pin change requests
  input  wire logic          ext_irq_zero_i,
  input  wire logic          ext_irq_one_i,
  input  wire logic          pin_change_irq_zero_i,
  input  wire logic          pin_change_irq_one_i,
  input  wire logic          pin_change_irq_two_i,
  // watchdog and timer 2 requests
  input  wire logic          watchdog_timeout_irq_i,
  input  wire logic          tmr2_match_a_irq_i,
  input  wire logic          tmr2_match_b_irq_i,
  input  wire logic          tmr2_overflow_irq_i,
  // timer 1 requests
  input  wire logic          tmr1_capture_irq_i,
  input  wire logic          tmr1_match_a_irq_i,
  input  wire logic          tmr1_match_b_irq_i,
  input  wire logic          tmr1_overflow_irq_i,
  // timer 0 requests
  input  wire logic          tmr0_match_a_irq_i,
  input  wire logic          tmr0_match_b_irq_i,
  input  wire logic          tmr0_overflow_irq_i,
  // serial requests
  input  wire logic          spi_done_irq_i,
  input  wire logic          rx_complete_irq_i,
  input  wire logic          tx_buffer_empty_irq_i,
  input  wire logic          tx_complete_irq_i,
  // converter, memory and comparator requests
  input  wire logic          conv_done_irq_i,
  input  wire logic          nv_data_ready_irq_i,
  input  wire logic          analog_cmp_irq_i,
  // two wire and program store requests
  input  wire logic          two_wire_irq_i,
  input  wire logic          program_store_ready_irq_i,
  // per source and global enables
  input  wire logic [N-1:0]  irq_enable_i,
  input  wire logic          global_enable_i,
  // fetch acknowledge from the core
  input  wire logic          ack_i,
  // presented vector
  output logic               vec_valid_o,
  output logic               vec_is_reset_o,
  output logic [RIVM_NUM_W-1:0] vec_num_o,
  output logic [AW-1:0]      vec_addr_o
);

  // ==========================================================================
  // request vector, bit index equals vector number minus one
  logic [N-1:0] req;
  logic [N-1:0] pend;

  // gather the request lines, one bit per source in table order
  always_comb begin
    req                       = '0;

    req[RIVM_SRC_EXT0]        = ext_irq_zero_i;
    req[RIVM_SRC_EXT1]        = ext_irq_one_i;

    req[RIVM_SRC_PC0]         = pin_change_irq_zero_i;
    req[RIVM_SRC_PC1]         = pin_change_irq_one_i;
    req[RIVM_SRC_PC2]         = pin_change_irq_two_i;
    req[RIVM_SRC_WDOG]        = watchdog_timeout_irq_i;

    req[RIVM_SRC_T2_A]        = tmr2_match_a_irq_i;
    req[RIVM_SRC_T2_B]        = tmr2_match_b_irq_i;
    req[RIVM_SRC_T2_OVF]      = tmr2_overflow_irq_i;

    req[RIVM_SRC_T1_CAP]      = tmr1_capture_irq_i;
    req[RIVM_SRC_T1_A]        = tmr1_match_a_irq_i;
    req[RIVM_SRC_T1_B]        = tmr1_match_b_irq_i;
    req[RIVM_SRC_T1_OVF]      = tmr1_overflow_irq_i;

    req[RIVM_SRC_T0_A]        = tmr0_match_a_irq_i;
    req[RIVM_SRC_T0_B]        = tmr0_match_b_irq_i;
    req[RIVM_SRC_T0_OVF]      = tmr0_overflow_irq_i;

    req[RIVM_SRC_SPI]         = spi_done_irq_i;

    req[RIVM_SRC_RX]          = rx_complete_irq_i;
    req[RIVM_SRC_TXE]         = tx_buffer_empty_irq_i;
    req[RIVM_SRC_TXC]         = tx_complete_irq_i;

    req[RIVM_SRC_CONV]        = conv_done_irq_i;
    req[RIVM_SRC_NV]          = nv_data_ready_irq_i;
    req[RIVM_SRC_ACMP]        = analog_cmp_irq_i;

    req[RIVM_SRC_TWO_WIRE]    = two_wire_irq_i;
    req[RIVM_SRC_PSTORE]      = program_store_ready_irq_i;
  end

  // disabled sources never fetch, so their slots may hold code
  always_comb begin
    pend = global_enable_i ? (req & irq_enable_i) : '0;
  end

  // ==========================================================================
  // priority pick and address mapping
  logic                  any_pend;
  logic [RIVM_NUM_W-1:0] win_idx;
  logic [AW-1:0]         win_addr;

  // fixed priority keeps the choice repeatable; the price is that a
  // flood of low index requests can starve the top entries
  // lowest number wins
  rivm_prio_enc #(
    .N (N),
    .W (RIVM_NUM_W)
  ) u_prio (
    .req_i (pend),
    .any_o (any_pend),
    .idx_o (win_idx)
  );

  // select is read live at the pick, so it must settle before enabling
  // boot relocation
  rivm_addr_map #(
    .AW (AW),
    .W  (RIVM_NUM_W)
  ) u_map (
    .idx_i        (win_idx),
    .table_sel_i  (vector_table_select_i),
    .boot_start_i (BOOT_START),
    .addr_o       (win_addr)
  );

  // ==========================================================================
  // reset vector choice
  logic [AW-1:0] reset_addr;

  // only read in the reset state, so a later fuse change has no effect
  // boot reset address
  always_comb begin
    if (boot_reset_fuse_i == RIVM_FUSE_PROGRAMMED) begin
      reset_addr = BOOT_START;
    end else begin
      reset_addr = AW'(RIVM_RESET_VEC);
    end
  end

  // ==========================================================================
  // fetch sequencer
  // sequencer state
  rivm_state_type        state;
  rivm_state_type        next_state;
  // presented vector, one flop per output
  logic                  valid;
  logic                  next_valid;
  logic                  is_reset;
  logic                  next_is_reset;
  logic [RIVM_NUM_W-1:0] num;
  logic [RIVM_NUM_W-1:0] next_num;
  logic [AW-1:0]         addr;
  logic [AW-1:0]         next_addr;

  // table slot of a source: slots start one above the reset slot
  function automatic logic [RIVM_NUM_W-1:0] slot_of(input logic [RIVM_NUM_W-1:0] idx);
    slot_of = RIVM_NUM_W'(idx + RIVM_NUM_W'(1));
  endfunction

  // vector held stable until acknowledged, so a late request cannot
  // change an address the core is already fetching
  always_comb begin
    next_state    = state;
    next_valid    = valid;
    next_is_reset = is_reset;
    next_num      = num;
    next_addr     = addr;
    case (state)
      RIVM_ST_RESET: begin
        // every reset kind lands here, so the first fetch is the reset slot
        // reset vector first
        next_valid    = 1'b1;
        next_is_reset = 1'b1;
        next_num      = '0;
        next_addr     = reset_addr;
        next_state    = RIVM_ST_WAIT;
      end
      RIVM_ST_IDLE: begin
        // picks happen only here, so a fetch in flight is never torn
        if (any_pend) begin
          next_valid    = 1'b1;
          next_is_reset = 1'b0;
          next_num      = slot_of(win_idx);
          next_addr     = win_addr;
          next_state    = RIVM_ST_WAIT;
        end
      end
      RIVM_ST_WAIT: begin
        // only this state listens to ack, a stray one while idle is dropped
        if (ack_i) begin
          next_valid = 1'b0;
          next_state = RIVM_ST_IDLE;
        end
      end
      default: begin
        // unused encoding falls back to a fresh reset vector
        next_state = RIVM_ST_RESET;
      end
    endcase
  end

  // state registers; reset clears the outputs and the reset slot
  // appears one edge after release
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state    <= RIVM_ST_RESET;
      valid    <= 1'b0;
      is_reset <= 1'b0;
      num      <= '0;
      addr     <= '0;
    end else begin
      state    <= next_state;
      valid    <= next_valid;
      is_reset <= next_is_reset;
      num      <= next_num;
      addr     <= next_addr;
    end
  end

  // outputs straight from flops, so the core never sees a glitching address
  assign vec_valid_o    = valid;
  assign vec_is_reset_o = is_reset;
  assign vec_num_o      = num;
  assign vec_addr_o     = addr;

endmodule

`default_nettype wire

// ===== test/rivm_properties.sv
/*
  concurrent checks on the vector mapper top ports.
  assumes one clock domain; attached to rivm_top by the bind below.
*/
`timescale 1ns/1ps
`default_nettype none

// ==========
// checker
module rivm_properties
  import rivm_pkg::*;
#(
  parameter int unsigned   AW         = RIVM_ADDR_W,
  parameter int unsigned   N          = RIVM_NUM_IRQ,
  parameter logic [AW-1:0] BOOT_START = RIVM_BOOT_START_DEF
) (
  // clock and reset
  input wire logic                  clk_i,
  input wire logic                  arst_n_i,
  // controls and requests
  input wire logic                  boot_reset_fuse_i,
  input wire logic                  vector_table_select_i,
  input wire logic                  ext_irq_zero_i,
  input wire logic [N-1:0]          irq_enable_i,
  input wire logic                  global_enable_i,
  input wire logic                  ack_i,
  // core side
  input wire logic                  vec_valid_o,
  input wire logic                  vec_is_reset_o,
  input wire logic [RIVM_NUM_W-1:0] vec_num_o,
  input wire logic [AW-1:0]         vec_addr_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  a_reset_vec_addr: assert property (vec_valid_o && vec_is_reset_o |->
    vec_num_o == 5'h00 && vec_addr_o == (boot_reset_fuse_i ? {AW{1'b0}} : BOOT_START))
    else $error("reset vector address wrong");
  a_vec_addr_map: assert property ($rose(vec_valid_o) && !vec_is_reset_o |->
    vec_addr_o == ($past(vector_table_select_i) ? BOOT_START : {AW{1'b0}}) + AW'(vec_num_o))
    else $error("vector address not offset plus base");
  a_first_reset: assert property ($rose(arst_n_i) |=> vec_valid_o && vec_is_reset_o)
    else $error("reset vector not presented after release");
  a_hold_until_ack: assert property (vec_valid_o && !ack_i |=> vec_valid_o && $stable(vec_addr_o)
    && $stable(vec_num_o) && $stable(vec_is_reset_o)) else $error("vector changed before ack");
  a_ack_release: assert property (vec_valid_o && ack_i |=> !vec_valid_o)
    else $error("valid held after ack");
  a_lowest_first: assert property (arst_n_i && $past(arst_n_i) && !vec_valid_o && global_enable_i
    && ext_irq_zero_i && irq_enable_i[0] |-> ##[1:2] (vec_valid_o && vec_num_o == 5'h01))
    else $error("lowest request not delivered");
  a_global_gate: assert property ($rose(vec_valid_o) && !vec_is_reset_o |-> $past(global_enable_i))
    else $error("vector picked while globally blocked");
  a_num_range: assert property (vec_valid_o && !vec_is_reset_o |->
    vec_num_o >= 5'h01 && vec_num_o <= 5'h19) else $error("vector number outside table");

  // main scenarios reached
  c_boot_reset: cover property (vec_valid_o && vec_is_reset_o && !boot_reset_fuse_i);
  c_relocated: cover property (vec_valid_o && vector_table_select_i && !vec_is_reset_o);
  c_last_entry: cover property (vec_valid_o && vec_num_o == 5'h19);
endmodule

bind rivm_top rivm_properties #(.AW(AW), .N(N), .BOOT_START(BOOT_START)) u_props (
  .clk_i(clk_i), .arst_n_i(arst_n_i), .boot_reset_fuse_i(boot_reset_fuse_i),
  .vector_table_select_i(vector_table_select_i), .ext_irq_zero_i(ext_irq_zero_i),
  .irq_enable_i(irq_enable_i), .global_enable_i(global_enable_i), .ack_i(ack_i),
  .vec_valid_o(vec_valid_o), .vec_is_reset_o(vec_is_reset_o), .vec_num_o(vec_num_o), .vec_addr_o(vec_addr_o));

`default_nettype wire

// ===== test/rivm_core_model.sv
/*
  behavioural core that fetches presented vectors.
  assumes delay_i is held steady while a vector is shown.
*/
`timescale 1ns/1ps
`default_nettype none

// ==========
// core model
module rivm_core_model (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       arst_n_i,
  // fetch side
  input  wire logic       vec_valid_i,
  input  wire logic [3:0] delay_i,
  output logic            ack_o
);
  logic [3:0] wait_cnt;

  // one ack pulse per vector, after delay_i idle cycles of fetch latency
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wait_cnt <= 4'h0;
      ack_o    <= 1'b0;
    end else begin
      ack_o <= 1'b0;
      if (vec_valid_i && !ack_o) begin
        if (wait_cnt >= delay_i) begin
          ack_o    <= 1'b1;
          wait_cnt <= 4'h0;
        end else begin
          wait_cnt <= wait_cnt + 4'h1;
        end
      end
    end
  end
endmodule

`default_nettype wire

// ===== test/rivm_top_test.sv
/*
  self-checking bench for the vector mapper.
  assumes the core model answers every vector; inputs change at falling edges.
*/
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin miscompares++; \
  $display("[ERR] %0t got %h expected %h", $time, got, exp); end end

// ==========
// bench
module rivm_top_test;
  import rivm_pkg::*;
  localparam logic [11:0] BOOT = 12'hc00;
  logic        clk_i;
  logic        arst_n_i;
  logic        fuse;
  logic        sel;
  logic [24:0] req;
  logic [24:0] en;
  logic        gen;
  logic [3:0]  delay;
  logic        ack;
  logic        valid;
  logic        is_rst;
  logic [4:0]  num;
  logic [11:0] addr;
  int          miscompares;
  int          n_checks;

  // clock at 25 MHz
  always #20 clk_i = ~clk_i;

  rivm_core_model core (.clk_i(clk_i), .arst_n_i(arst_n_i), .vec_valid_i(valid), .delay_i(delay), .ack_o(ack));

  rivm_top #(.BOOT_START(BOOT)) uut (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .boot_reset_fuse_i(fuse), .vector_table_select_i(sel),
    .ext_irq_zero_i(req[0]), .ext_irq_one_i(req[1]), .pin_change_irq_zero_i(req[2]),
    .pin_change_irq_one_i(req[3]), .pin_change_irq_two_i(req[4]), .watchdog_timeout_irq_i(req[5]),
    .tmr2_match_a_irq_i(req[6]), .tmr2_match_b_irq_i(req[7]), .tmr2_overflow_irq_i(req[8]),
    .tmr1_capture_irq_i(req[9]), .tmr1_match_a_irq_i(req[10]), .tmr1_match_b_irq_i(req[11]),
    .tmr1_overflow_irq_i(req[12]), .tmr0_match_a_irq_i(req[13]), .tmr0_match_b_irq_i(req[14]),
    .tmr0_overflow_irq_i(req[15]), .spi_done_irq_i(req[16]), .rx_complete_irq_i(req[17]),
    .tx_buffer_empty_irq_i(req[18]), .tx_complete_irq_i(req[19]), .conv_done_irq_i(req[20]),
    .nv_data_ready_irq_i(req[21]), .analog_cmp_irq_i(req[22]), .two_wire_irq_i(req[23]),
    .program_store_ready_irq_i(req[24]), .irq_enable_i(en), .global_enable_i(gen), .ack_i(ack),
    .vec_valid_o(valid), .vec_is_reset_o(is_rst), .vec_num_o(num), .vec_addr_o(addr));

  task automatic complete_run();
    if (miscompares == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // wait for a vector, judge it, retire its request, wait for the ack to clear it
  task automatic take(input logic [4:0] exp_num, input logic [11:0] exp_addr);
    int k;
    for (k = 0; k < 40 && valid !== 1'b1; k++) @(negedge clk_i);
    if (valid !== 1'b1) begin
      miscompares++;
      $display("[ERR] %0t no vector presented", $time);
      complete_run();
    end else begin
      `CHK(num, exp_num)
      `CHK(addr, exp_addr)
      `CHK(is_rst, (exp_num == 5'h00))
      if (exp_num != 5'h00) req[exp_num - 5'h01] = 1'b0;
      for (k = 0; k < 40 && valid !== 1'b0; k++) @(negedge clk_i);
      if (valid !== 1'b0) begin
        miscompares++;
        $display("[ERR] %0t vector never released", $time);
        complete_run();
      end
    end
  endtask

  task automatic s_reset(input logic f);
    arst_n_i = 1'b0;
    fuse     = f;
    repeat (12) @(negedge clk_i);
    arst_n_i = 1'b1;
    take(5'h00, f ? 12'h000 : BOOT);
  endtask

  task automatic s_map_all(input logic s);
    en  = '0;
    sel = s;
    @(negedge clk_i);
    en  = '1;
    gen = 1'b1;
    for (int i = 0; i < 25; i++) begin
      delay  = 4'(i % 4);
      req[i] = 1'b1;
      take(5'(i + 1), (s ? BOOT : 12'h000) + 12'(i + 1));
    end
  endtask

  task automatic s_priority();
    sel = 1'b0;
    en  = 25'h1ffff7f;
    req = 25'h1000088;
    take(5'h04, 12'h004);
    take(5'h19, 12'h019);
    repeat (6) @(negedge clk_i) `CHK(valid, 1'b0)
    gen = 1'b0;
    en  = '1;
    repeat (4) @(negedge clk_i) `CHK(valid, 1'b0)
    gen = 1'b1;
    take(5'h08, 12'h008);
  endtask

  // main sequence, second reset in mid-run with the fuse programmed
  initial begin
    clk_i = 1'b0; arst_n_i = 1'b0; fuse = 1'b1; sel = 1'b0; req = '0; en = '0;
    gen = 1'b0; delay = 4'h0; miscompares = 0; n_checks = 0;
    s_reset(1'b1);
    s_map_all(1'b0);
    s_priority();
    s_map_all(1'b1);
    en = '0;
    s_reset(1'b0);
    s_map_all(1'b0);
    s_map_all(1'b1);
    complete_run();
  end
endmodule

`default_nettype wire
